// ===== pie_pkg.sv
// Package for the PHY interrupt-enable and generic-status register bank.
// Assumes one 20 MHz clock and a management port of 5-bit register numbers.
package pie_pkg;

   // ---------------------------------------------------------------
   // Widths and register numbers
   // ---------------------------------------------------------------
   localparam int PIE_ADDR_W = 5;
   localparam int PIE_DATA_W = 16;
   localparam int PIE_EVT_W = 10;
   localparam logic [4:0] PIE_OFF_FSEL_CTRL = 5'h11;
   localparam logic [4:0] PIE_OFF_IRQ_CFG = 5'h12;
   localparam logic [4:0] PIE_OFF_IRQ_EN = 5'h14;
   localparam logic [4:0] PIE_OFF_IRQ_STS = 5'h15;
   localparam logic [4:0] PIE_OFF_GEN_STS = 5'h16;
   localparam logic [4:0] PIE_OFF_STS_LAST = 5'h1c;
   localparam logic [4:0] PIE_OFF_RSV_FIRST = 5'h1d;
   localparam logic [4:0] PIE_OFF_RSV_LAST = 5'h1e;

   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int PIE_FSEL_CTRL_BIT = 9;
   localparam int PIE_POL_BIT = 1;
   localparam logic [9:0] PIE_IRQ_EN_RST = 10'h3ff;
   localparam logic [15:0] PIE_GEN_STS_RST = 16'h0000;
   localparam logic PIE_FSEL_CTRL_RST = 1'b0;
   localparam logic PIE_POL_RST = 1'b0;
   // Events that fire on any change rather than on a rise
   localparam logic [9:0] PIE_CHANGE_MASK = 10'h3a0;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic {
      PIE_ST_CAPTURE = 1'b0,
      PIE_ST_RUN = 1'b1
   } pie_state_t;

   // Cable length codes, meaningful only at 100M
   typedef enum logic [7:0] {
      PIE_CBL_40M = 8'h1a,
      PIE_CBL_60M = 8'h22,
      PIE_CBL_80M = 8'h94,
      PIE_CBL_100M = 8'h9a,
      PIE_CBL_120M = 8'ha2,
      PIE_CBL_140M = 8'hab
   } pie_cable_len_t;

   // Bit order equals the enable register layout, bit 9 first
   typedef struct packed {
      logic crossover;
      logic speed_100;
      logic full_duplex;
      logic page_rx;
      logic link_up;
      logic symbol_error;
      logic false_carrier;
      logic tx_jabber;
      logic rx_jabber;
      logic error_end_stream;
   } pie_evt_t;

   typedef struct packed {
      logic medium_detect;
      logic fiber_select_strap;
      logic [7:0] cable_length_estimate;
   } pie_phy_in_t;

   typedef struct packed {
      logic [4:0] rsvd;
      logic medium_detect_status;
      logic fiber_mode_status;
      logic crossover_state;
      logic [7:0] cable_length_estimate;
   } pie_gen_sts_t;

endpackage : pie_pkg

// ===== pie_evt_latch.sv
// One event detector with a sticky status bit.
// Assumes the level input is synchronous to ref_clk.
`timescale 1ns/1ps
module pie_evt_latch #(
   parameter bit IS_CHANGE = 1'b0
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Event side
   input wire logic level,
   input wire logic arm,
   input wire logic clear,
   output logic pulse,
   output logic sticky
);

   logic prev_r;
   logic prev_nxt;
   logic sticky_r;
   logic sticky_nxt;

   always_comb begin
      prev_nxt = level;
      // A held strobe counts once; arm keeps the reset state from firing
      if (IS_CHANGE) begin
         pulse = arm && (level != prev_r);
      end else begin
         pulse = arm && level && !prev_r;
      end
      // Set beats clear in the same cycle
      sticky_nxt = pulse || (sticky_r && !clear);
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         prev_r <= 1'b0;
         sticky_r <= 1'b0;
      end else begin
         prev_r <= prev_nxt;
         sticky_r <= sticky_nxt;
      end
   end

   assign sticky = sticky_r;

endmodule : pie_evt_latch

// ===== pie_irq_status_bank.sv
// Interrupt enable, interrupt status and generic status registers of the PHY.
// Assumes a management master with one-cycle strobes and inputs on ref_clk.
`timescale 1ns/1ps

// Summary of operation
// - Bit 9 enables crossover change interrupt
// - Bit 8 enables speed change interrupt
// - Bit 7 enables duplex change interrupt
// - Bit 6 enables page received interrupt
// - Bit 5 enables link change interrupt
// - Bit 4 enables symbol error interrupt
// - Bit 3 enables false carrier interrupt
// - Bit 2 enables transmit jabber interrupt
// - Bit 1 enables receive jabber interrupt
// - Bit 0 error end-of-stream; bits 15:10 read zero
// - Status at numbers 22-28; 29-30 reserved
// - Bit 10 shows live medium detect
// - Bit 9 fiber mode, captured at reset
// - Config bit selects interrupt output polarity
module pie_irq_status_bank #(
   parameter int ADDR_W = pie_pkg::PIE_ADDR_W
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // PHY state
   input wire pie_pkg::pie_evt_t phy_evt,
   input wire pie_pkg::pie_phy_in_t phy_in,
   // Outputs
   output logic irq_out,
   output logic fiber_mode
);

   // ---------------------------------------------------------------
   // Parameter check
   // ---------------------------------------------------------------
   if (ADDR_W < pie_pkg::PIE_ADDR_W) begin : g_bad_addr_w
      $error("ADDR_W too narrow for register numbers");
   end

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] A_FSEL = ADDR_W'(pie_pkg::PIE_OFF_FSEL_CTRL);
   localparam logic [ADDR_W-1:0] A_CFG = ADDR_W'(pie_pkg::PIE_OFF_IRQ_CFG);
   localparam logic [ADDR_W-1:0] A_IRQ_EN = ADDR_W'(pie_pkg::PIE_OFF_IRQ_EN);
   localparam logic [ADDR_W-1:0] A_STS = ADDR_W'(pie_pkg::PIE_OFF_IRQ_STS);
   localparam logic [ADDR_W-1:0] A_GEN_STS = ADDR_W'(pie_pkg::PIE_OFF_GEN_STS);
   localparam logic [ADDR_W-1:0] A_RSV0 = ADDR_W'(pie_pkg::PIE_OFF_RSV_FIRST);
   localparam logic [ADDR_W-1:0] A_RSV1 = ADDR_W'(pie_pkg::PIE_OFF_RSV_LAST);
   localparam int EW = pie_pkg::PIE_EVT_W;

   pie_pkg::pie_state_t st_r;
   pie_pkg::pie_state_t st_nxt;
   logic [EW-1:0] irq_en_r;
   logic [EW-1:0] irq_en_nxt;
   logic fsel_ctrl_r;
   logic fsel_ctrl_nxt;
   logic pol_r;
   logic pol_nxt;
   logic fiber_r;
   logic fiber_nxt;
   logic [15:0] rdata_r;
   logic [15:0] rdata_nxt;

   logic [EW-1:0] evt_vec;
   logic [EW-1:0] evt_pulse;
   logic [EW-1:0] sts;
   logic arm;
   logic sts_clr;
   logic irq_active;
   pie_pkg::pie_gen_sts_t gen_sts;

   // ---------------------------------------------------------------
   // Reset capture sequencer
   // ---------------------------------------------------------------
   // Fiber mode is latched once, in the first cycle after reset release;
   // later writes to the select bit never take effect, as reset clears it before the capture.
   always_comb begin
      st_nxt = st_r;
      fiber_nxt = fiber_r;
      case (st_r)
         pie_pkg::PIE_ST_CAPTURE: begin
            fiber_nxt = phy_in.fiber_select_strap | fsel_ctrl_r;
            st_nxt = pie_pkg::PIE_ST_RUN;
         end
         pie_pkg::PIE_ST_RUN: begin
            st_nxt = pie_pkg::PIE_ST_RUN;
         end
         default: begin
            st_nxt = pie_pkg::PIE_ST_CAPTURE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         st_r <= pie_pkg::PIE_ST_CAPTURE;
         fiber_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         fiber_r <= fiber_nxt;
      end
   end

   // Detectors stay quiet until their previous levels are loaded
   assign arm = (st_r == pie_pkg::PIE_ST_RUN);

   // ---------------------------------------------------------------
   // Event detectors and sticky status
   // ---------------------------------------------------------------
   assign evt_vec = phy_evt;
   assign sts_clr = reg_rd && (reg_addr == A_STS);

   for (genvar i = 0; i < EW; i++) begin : g_evt
      pie_evt_latch #(
         .IS_CHANGE(pie_pkg::PIE_CHANGE_MASK[i])
      ) u_evt (
         .ref_clk(ref_clk),
         .reset(reset),
         .level(evt_vec[i]),
         .arm(arm),
         .clear(sts_clr),
         .pulse(evt_pulse[i]),
         .sticky(sts[i])
      );
   end

   // ---------------------------------------------------------------
   // Interrupt output
   // ---------------------------------------------------------------
   // Status latches every event; the enables only gate the output
   assign irq_active = |(sts & irq_en_r);
   assign irq_out = pol_r ? irq_active : !irq_active;
   assign fiber_mode = fiber_r;

   // ---------------------------------------------------------------
   // Generic status view
   // ---------------------------------------------------------------
   always_comb begin
      gen_sts = pie_pkg::PIE_GEN_STS_RST;
      gen_sts.medium_detect_status = phy_in.medium_detect;
      gen_sts.fiber_mode_status = fiber_r;
      gen_sts.crossover_state = phy_evt.crossover;
      // Estimate is meaningless at 10M, so it reads zero there
      if (phy_evt.speed_100) begin
         gen_sts.cable_length_estimate = phy_in.cable_length_estimate;
      end
   end

   // ---------------------------------------------------------------
   // Register writes
   // ---------------------------------------------------------------
   always_comb begin
      irq_en_nxt = irq_en_r;
      fsel_ctrl_nxt = fsel_ctrl_r;
      pol_nxt = pol_r;
      if (reg_wr && reg_addr == A_IRQ_EN) begin
         // Bits 15:10 are dropped on write
         irq_en_nxt = reg_wdata[EW-1:0];
      end else if (reg_wr && reg_addr == A_FSEL) begin
         fsel_ctrl_nxt = reg_wdata[pie_pkg::PIE_FSEL_CTRL_BIT];
      end else if (reg_wr && reg_addr == A_CFG) begin
         pol_nxt = reg_wdata[pie_pkg::PIE_POL_BIT];
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         irq_en_r <= pie_pkg::PIE_IRQ_EN_RST;
         fsel_ctrl_r <= pie_pkg::PIE_FSEL_CTRL_RST;
         pol_r <= pie_pkg::PIE_POL_RST;
      end else begin
         irq_en_r <= irq_en_nxt;
         fsel_ctrl_r <= fsel_ctrl_nxt;
         pol_r <= pol_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Register reads
   // ---------------------------------------------------------------
   // Data stand one cycle after the strobe and read zero otherwise.
   // Numbers 23 to 28 belong to other status blocks and read zero here.
   always_comb begin
      rdata_nxt = 16'h0000;
      if (!reg_rd) begin
         rdata_nxt = 16'h0000;
      end else if (reg_addr == A_IRQ_EN) begin
         rdata_nxt = {6'h00, irq_en_r};
      end else if (reg_addr == A_STS) begin
         rdata_nxt = {6'h00, sts};
      end else if (reg_addr == A_GEN_STS) begin
         rdata_nxt = gen_sts;
      end else if (reg_addr == A_FSEL) begin
         rdata_nxt[pie_pkg::PIE_FSEL_CTRL_BIT] = fsel_ctrl_r;
      end else if (reg_addr == A_CFG) begin
         rdata_nxt[pie_pkg::PIE_POL_BIT] = pol_r;
      end else begin
         rdata_nxt = 16'h0000;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rdata_r <= 16'h0000;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   sequence s_read(logic [ADDR_W-1:0] a);
      reg_rd && (reg_addr == a);
   endsequence

   sequence s_write(logic [ADDR_W-1:0] a);
      reg_wr && (reg_addr == a);
   endsequence

   // An enabled event raises the interrupt in the next cycle
   property p_raise(logic ev, logic en);
      ev && en |=> irq_active;
   endproperty

   chk_crossover_state_raise: assert property (p_raise(evt_pulse[9], irq_en_r[9]))
      else $error("crossover change did not raise interrupt");
   chk_speed_raise: assert property (p_raise(evt_pulse[8], irq_en_r[8]))
      else $error("speed change did not raise interrupt");
   chk_duplex_raise: assert property (p_raise(evt_pulse[7], irq_en_r[7]))
      else $error("duplex change did not raise interrupt");
   chk_page_raise: assert property (p_raise(evt_pulse[6], irq_en_r[6]))
      else $error("page received did not raise interrupt");
   chk_link_raise: assert property (p_raise(evt_pulse[5], irq_en_r[5]))
      else $error("link change did not raise interrupt");
   chk_symerr_raise: assert property (p_raise(evt_pulse[4], irq_en_r[4]))
      else $error("symbol error did not raise interrupt");
   chk_false_carrier_irq_en_raise: assert property (p_raise(evt_pulse[3], irq_en_r[3]))
      else $error("false carrier did not raise interrupt");
   chk_txjab_raise: assert property (p_raise(evt_pulse[2], irq_en_r[2]))
      else $error("transmit jabber did not raise interrupt");
   chk_rxjab_raise: assert property (p_raise(evt_pulse[1], irq_en_r[1]))
      else $error("receive jabber did not raise interrupt");
   chk_ees_raise: assert property (p_raise(evt_pulse[0], irq_en_r[0]))
      else $error("error end of stream did not raise interrupt");

   chk_enable_readback: assert property (
      s_write(A_IRQ_EN) ##1 s_read(A_IRQ_EN) |=>
         reg_rdata == {6'h00, $past(reg_wdata[EW-1:0], 2)})
      else $error("enable register readback wrong");

   chk_reserved_zero: assert property (
      (s_read(A_RSV0) or s_read(A_RSV1)) |=> reg_rdata == 16'h0000)
      else $error("reserved register read nonzero");

   chk_medium_live: assert property (
      s_read(A_GEN_STS) |=> reg_rdata[10] == $past(phy_in.medium_detect))
      else $error("medium detect bit not live");

   chk_fiber_hold: assert property (
      arm ##1 arm |-> $stable(fiber_r) && reg_rdata[15:11] == 5'h00)
      else $error("fiber mode changed outside reset");

   chk_fiber_cap: assert property (
      st_r == pie_pkg::PIE_ST_CAPTURE |=>
         fiber_r == $past(phy_in.fiber_select_strap | fsel_ctrl_r))
      else $error("fiber mode capture wrong");

   chk_crossover_state_bit: assert property (
      s_read(A_GEN_STS) |=> reg_rdata[8] == $past(phy_evt.crossover))
      else $error("crossover state bit wrong");

   chk_cable_len: assert property (
      s_read(A_GEN_STS) |=> reg_rdata[7:0] ==
         ($past(phy_evt.speed_100) ? $past(phy_in.cable_length_estimate) : 8'h00))
      else $error("cable length field wrong");

   chk_irq_gated: assert property (
      (irq_en_r == 10'h000) |-> !irq_active ##1 (irq_en_r != 10'h000 || !irq_active))
      else $error("interrupt with all enables off");

   chk_sts_clear: assert property (
      s_read(A_STS) ##0 (evt_pulse == 10'h000) |=> sts == 10'h000 && !irq_active)
      else $error("status not cleared by read");

   chk_polarity: assert property (
      (irq_active |-> irq_out == pol_r) and (!irq_active |-> irq_out == !pol_r))
      else $error("interrupt polarity wrong");

endmodule : pie_irq_status_bank

// ===== pie_mgmt_host.sv
// Management host model for the PHY register bank.
// Assumes one-cycle strobes sampled on the rising edge of ref_clk.
`timescale 1ns/1ps
module pie_mgmt_host (
   // Clock
   input wire logic ref_clk,
   // Register port
   output logic [4:0] reg_addr,
   output logic [15:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [15:0] reg_rdata
);
   initial begin
      reg_addr = 5'h00;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   task reg_write(input logic [4:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : reg_write

   // Write followed at once by a read of the same register
   task reg_write_read(input logic [4:0] a, input logic [15:0] d, output logic [15:0] q);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      q = reg_rdata;
   endtask : reg_write_read

   // Data stands for one cycle only, so sample it mid-cycle
   task reg_read(input logic [4:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      d = reg_rdata;
   endtask : reg_read
endmodule : pie_mgmt_host

// ===== pie_irq_status_bank_tb.sv
// Self-checking bench for the interrupt-enable and generic-status bank.
// Assumes the host model drives the register port; bench drives PHY state.
`timescale 1ns/1ps
module pie_irq_status_bank_tb;
   logic ref_clk;
   logic reset;
   logic [4:0] reg_addr;
   logic [15:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [15:0] reg_rdata;
   logic [9:0] evt;
   pie_pkg::pie_phy_in_t phy_in;
   logic irq_out;
   logic fiber_mode;
   int fails;
   int checked;
   logic [15:0] v;
   logic [7:0] codes [6] = '{8'h1a, 8'h22, 8'h94, 8'h9a, 8'ha2, 8'hab};

   pie_irq_status_bank i_pie_irq_status_bank (.ref_clk(ref_clk), .reset(reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .phy_evt(evt), .phy_in(phy_in), .irq_out(irq_out),
      .fiber_mode(fiber_mode));

   pie_mgmt_host i_pie_mgmt_host (.ref_clk(ref_clk), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task final_report;
      $display("Comparisons %0d, mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : final_report

   task settle;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask : settle

   function automatic logic [15:0] gen_sts_exp(input logic fib);
      return {5'b0, phy_in.medium_detect, fib, evt[9],
         evt[8] ? phy_in.cable_length_estimate : 8'h00};
   endfunction : gen_sts_exp

   // Enabled event must pull the line, disabled one must not
   task evt_case(input int i);
      logic [9:0] m;
      m = 10'(1) << i;
      i_pie_mgmt_host.reg_write(5'h14, {6'b0, m});
      @(posedge ref_clk);
      evt <= evt | m;
      settle();
      check({15'b0, irq_out}, 16'h0000);
      i_pie_mgmt_host.reg_read(5'h15, v);
      check(v, {6'b0, m});
      check({15'b0, irq_out}, 16'h0001);
      i_pie_mgmt_host.reg_write(5'h14, {6'b0, 10'h3ff ^ m});
      @(posedge ref_clk);
      evt <= evt & ~m;
      settle();
      check({15'b0, irq_out}, 16'h0001);
      i_pie_mgmt_host.reg_read(5'h15, v);
      check(v, {6'b0, m & pie_pkg::PIE_CHANGE_MASK});
      $display("Event test done for bit %0d", i);
   endtask : evt_case

   task pulse_reset;
      @(posedge ref_clk);
      reset <= 1'b1;
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
   endtask : pulse_reset

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      fails = 0;
      checked = 0;
      reset = 1'b1;
      evt = 10'h000;
      phy_in = '0;
      repeat (20) @(posedge ref_clk);
      reset <= 1'b0;
      @(negedge ref_clk);
      check({15'b0, irq_out}, 16'h0001);
      i_pie_mgmt_host.reg_read(5'h14, v);
      check(v, 16'h03ff);
      @(negedge ref_clk);
      check(reg_rdata, 16'h0000);
      i_pie_mgmt_host.reg_read(5'h16, v);
      check(v, 16'h0000);
      $display("Reset values test done");

      i_pie_mgmt_host.reg_write_read(5'h14, 16'hffff, v);
      check(v, 16'h03ff);
      i_pie_mgmt_host.reg_write_read(5'h14, 16'h0000, v);
      check(v, 16'h0000);
      i_pie_mgmt_host.reg_read(5'h1d, v);
      check(v, 16'h0000);
      i_pie_mgmt_host.reg_read(5'h1e, v);
      check(v, 16'h0000);
      i_pie_mgmt_host.reg_write(5'h16, 16'hffff);
      i_pie_mgmt_host.reg_read(5'h16, v);
      check(v, gen_sts_exp(1'b0));
      $display("Map test done");

      evt_case(9);
      evt_case(8);
      evt_case(7);
      evt_case(6);
      evt_case(5);
      evt_case(4);
      evt_case(3);
      evt_case(2);
      evt_case(1);
      evt_case(0);

      // Active-high line idles low
      i_pie_mgmt_host.reg_write(5'h14, 16'h03ff);
      i_pie_mgmt_host.reg_write(5'h12, 16'h0002);
      @(negedge ref_clk);
      check({15'b0, irq_out}, 16'h0000);
      @(posedge ref_clk);
      evt <= 10'h010;
      settle();
      check({15'b0, irq_out}, 16'h0001);
      i_pie_mgmt_host.reg_read(5'h15, v);
      check({15'b0, irq_out}, 16'h0000);
      i_pie_mgmt_host.reg_write(5'h12, 16'h0000);
      @(negedge ref_clk);
      check({15'b0, irq_out}, 16'h0001);
      evt <= 10'h000;
      $display("Polarity test done");

      @(posedge ref_clk);
      evt <= 10'h300;
      phy_in.medium_detect <= 1'b1;
      for (int k = 0; k < 6; k++) begin
         phy_in.cable_length_estimate <= codes[k];
         i_pie_mgmt_host.reg_read(5'h16, v);
         check(v, {5'b0, 3'b101, codes[k]});
      end
      phy_in.medium_detect <= 1'b0;
      i_pie_mgmt_host.reg_read(5'h16, v);
      check(v, {5'b0, 3'b001, codes[5]});
      evt <= 10'h000;
      i_pie_mgmt_host.reg_read(5'h16, v);
      check(v, 16'h0000);
      i_pie_mgmt_host.reg_read(5'h15, v);
      $display("Generic status test done");

      phy_in.fiber_select_strap <= 1'b1;
      pulse_reset();
      phy_in.fiber_select_strap <= 1'b0;
      i_pie_mgmt_host.reg_read(5'h16, v);
      check(v, 16'h0200);
      check({15'b0, fiber_mode}, 16'h0001);
      pulse_reset();
      i_pie_mgmt_host.reg_read(5'h16, v);
      check(v, 16'h0000);
      $display("Fiber capture test done");
      final_report();
   end

   // Whole run is a few hundred cycles
   initial begin
      repeat (20000) @(posedge ref_clk);
      fails++;
      final_report();
   end
endmodule : pie_irq_status_bank_tb
